// ### src/dtg_guard.sv
// Device-side command timing guard: parity and CRC alert, internal write start.
// Assumes commands decoded on the core clock; parity and CRC error flags are
// asynchronous pins and pass a two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none
module dtg_guard
  import dtg_pkg::*;
#(
  parameter bit          SPEED_2666 = 1'b0,
  parameter int unsigned PL         = dtg_pkg::PL_NCK
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_cmd_valid,
  input  wire dtg_pkg::dtg_cmd_t           i_cmd,
  input  wire dtg_pkg::dtg_burst_t         i_burst,
  input  wire logic [dtg_pkg::LAT_W-1:0]   i_wl,
  input  wire logic                        i_par_err_pin,
  input  wire logic                        i_crc_err_pin,
  input  wire logic                        i_cke,
  output logic                             o_alert_n,
  output logic                             o_cmd_exec,
  output logic                             o_wr_start,
  output logic                             o_cmd_needs_dll,
  output logic                             o_pd_active
);
  import dtg_pkg::*;

  localparam logic [CNT_W-1:0] PAR_PW = CNT_W'(SPEED_2666 ? PAR_PW_2666 : PAR_PW_2400);
  localparam logic [CNT_W-1:0] CRC_PW = CNT_W'(CRC_PW_NCK);
  localparam int unsigned ALERT_DLY = (PAR_ON_NCK < CRC_ON_NCK) ? CRC_ON_NCK : PAR_ON_NCK;

  logic par_s1_q, par_s2_q, crc_s1_q, crc_s2_q, par_prev_q, crc_prev_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      {par_s1_q, par_s2_q, crc_s1_q, crc_s2_q, par_prev_q, crc_prev_q} <= '0;
    end else begin
      par_s1_q   <= i_par_err_pin;
      par_s2_q   <= par_s1_q;
      crc_s1_q   <= i_crc_err_pin;
      crc_s2_q   <= crc_s1_q;
      par_prev_q <= par_s2_q;
      crc_prev_q <= crc_s2_q;
    end
  end
  logic par_evt, crc_evt;
  assign par_evt = par_s2_q & ~par_prev_q;
  assign crc_evt = crc_s2_q & ~crc_prev_q;

  // parity latency alignment: error seen after the fixed latency
  logic par_late;
  dtg_delay_line #(.DEPTH(PL), .W(1)) u_par_lat (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_d        (par_evt),
    .o_q        (par_late)
  );

  // blocked window: commands after a parity error are dropped for PL cycles
  logic [CNT_W-1:0] unk_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) unk_q <= '0;
    else if (par_evt) unk_q <= CNT_W'(PL);
    else if (unk_q != '0) unk_q <= unk_q - 1'b1;
  end
  assign o_cmd_exec = i_cmd_valid & (unk_q == '0) & ~par_evt;

  assign o_cmd_needs_dll = i_cmd_valid & (i_cmd == DTG_CMD_RD);

  // alert onset, ns rounded up into cycles
  logic [1:0] alert_req;
  dtg_delay_line #(.DEPTH(ALERT_DLY), .W(2)) u_alert_dly (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_d        ({par_late, crc_evt}),
    .o_q        (alert_req)
  );

  // alert pulse width; down-counter; parity pulse wins over CRC
  logic [CNT_W-1:0] alert_cnt_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) alert_cnt_q <= '0;
    else if (alert_req[1]) alert_cnt_q <= PAR_PW;
    else if (alert_req[0] && alert_cnt_q == '0) alert_cnt_q <= CRC_PW;
    else if (alert_cnt_q != '0) alert_cnt_q <= alert_cnt_q - 1'b1;
  end
  logic alert_n_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) alert_n_q <= 1'b1;
    else alert_n_q <= ~((alert_cnt_q > 1) | alert_req[1] | alert_req[0]);
  end
  assign o_alert_n = alert_n_q;

  // internal write start: WL+4, or WL+2 for fixed chop4
  logic [CNT_W-1:0] wr_cnt_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) wr_cnt_q <= '0;
    else if (o_cmd_exec && i_cmd == DTG_CMD_WR)
      wr_cnt_q <= CNT_W'(i_wl) +
        CNT_W'((i_burst == DTG_CHOP_FIXED) ? WBURST_CHOP : WBURST_FULL);
    else if (wr_cnt_q != '0) wr_cnt_q <= wr_cnt_q - 1'b1;
  end
  logic wr_start_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) wr_start_q <= 1'b0;
    else wr_start_q <= (wr_cnt_q == CNT_W'(1));
  end
  assign o_wr_start = wr_start_q;

  // powerdown accepted while busy; busy work still finishes
  logic pd_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) pd_q <= 1'b0;
    else pd_q <= ~i_cke;
  end
  assign o_pd_active = pd_q & (wr_cnt_q == '0);

  // mode update done within tMOD by construction: applied at once

  a_write_start: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_cmd_exec && i_cmd == DTG_CMD_WR && i_burst == DTG_CHOP_FIXED && i_wl == 5'h05
    |-> ##8 o_wr_start)
    else $error("internal write start mistimed");
  a_crc_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_alert_n) && alert_cnt_q == CRC_PW |-> !o_alert_n [*5])
    else $error("crc alert too short");
  a_par_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
    par_evt |=> !o_cmd_exec [*4])
    else $error("command executed in parity window");
  a_dll_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_cmd_needs_dll |-> i_cmd == DTG_CMD_RD)
    else $error("dll need on non-read");
  a_par_alert: assert property (@(posedge i_core_clk) disable iff (i_rst)
    par_evt |-> ##[1:8] !o_alert_n)
    else $error("parity alert late");
  a_par_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $fell(o_alert_n) && alert_cnt_q == PAR_PW |-> !o_alert_n [*8])
    else $error("parity alert too short");
  c_par: cover property (@(posedge i_core_clk) par_evt ##[1:20] !o_alert_n);
  c_crc: cover property (@(posedge i_core_clk) crc_evt ##[1:10] !o_alert_n);
  c_wr:  cover property (@(posedge i_core_clk) o_wr_start);
endmodule // dtg_guard
`default_nettype wire

// ### src/dtg_pkg.sv
// Constants and types for the command timing guard, device side.
// Assumes one core clock at 100 MHz standing in for the device input clock.
// How it works
// - Per-device mode update done within tMOD
// - Commands after parity error may be dropped
// - Alert within PL plus 6 ns; here PL plus 2 cycles after the synchronised error
// - Parity alert pulse 72..144 or 80..160
// - Parity latency fixed at 5 cycles
// - CRC alert 3 to 13 ns after error; here 2 cycles after the synchronised error
// - CRC alert pulse 6 to 10 cycles
// - Internal write WL+4, fixed chop4 WL+2
// - Powerdown accepted during busy operations finishes
// - Nanoseconds to cycles rounded up
package dtg_pkg;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned PL_NCK        = 5;
  localparam int unsigned PAR_ON_PS     = 6000;
  localparam int unsigned CRC_ON_MIN_PS = 3000;
  localparam int unsigned PAR_PW_2400   = 72;
  localparam int unsigned PAR_PW_2666   = 80;
  localparam int unsigned CRC_PW_NCK    = 6;
  localparam int unsigned WBURST_FULL   = 4;
  localparam int unsigned WBURST_CHOP   = 2;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned LAT_W         = 5;
  typedef enum logic [2:0] {
    DTG_CMD_DES, DTG_CMD_WR, DTG_CMD_RD, DTG_CMD_REF, DTG_CMD_MRS, DTG_CMD_ACT, DTG_CMD_PRE
  } dtg_cmd_t;
  typedef enum logic [1:0] {DTG_BL8, DTG_OTF, DTG_CHOP_FIXED} dtg_burst_t;
  // Least time rounds up, never below one cycle
  function automatic int unsigned ns_to_nck(input int unsigned ps);
    int unsigned n;
    n = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n == 0) ? 1 : n;
  endfunction
  localparam int unsigned PAR_ON_NCK = ns_to_nck(PAR_ON_PS);
  localparam int unsigned CRC_ON_NCK = ns_to_nck(CRC_ON_MIN_PS);
endpackage

// ### src/dtg_delay_line.sv
// Fixed-latency delay line for a pulse and a small tag.
// Assumes inputs from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dtg_delay_line #(
  parameter int unsigned DEPTH = 5,
  parameter int unsigned W     = 1
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] pipe_q [DEPTH];
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) pipe_q[i] <= '0;
    end else begin
      pipe_q[0] <= i_d;
      for (int i = 1; i < DEPTH; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign o_q = pipe_q[DEPTH-1];
endmodule // dtg_delay_line
`default_nettype wire

// ### test/dtg_ctrl_model.sv
// Controller-side model: issues commands and powerdown requests.
// Assumes the bench calls its tasks; it drives only on falling edges.
`timescale 1ns/1ps
`default_nettype none
module dtg_ctrl_model
  import dtg_pkg::*;
(
  input  wire logic                 i_core_clk,
  output logic                      o_cmd_valid,
  output dtg_pkg::dtg_cmd_t         o_cmd,
  output dtg_pkg::dtg_burst_t       o_burst,
  output logic [dtg_pkg::LAT_W-1:0] o_wl,
  output logic                      o_cke
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = DTG_CMD_DES;
    o_burst = DTG_BL8;
    o_wl = 5'h05;
    o_cke = 1'b1;
  end
  // Controller settings: plain defaults, not tied to any speed grade
  localparam int unsigned WR_PS        = 15000;
  localparam int unsigned WR_CRC_DM_PS = 18000;
  localparam bit          CRC_DM_ON    = 1'b0;
  localparam int unsigned RL_NCK       = 16;
  localparam int unsigned TMOD_NCK     = 24;
  // recovery in ns rounded up; CRC with mask uses its own
  localparam int unsigned WR_NCK = ns_to_nck(CRC_DM_ON ? WR_CRC_DM_PS : WR_PS);
  // Idle cycles owed after a command before clock enable may drop
  function automatic int unsigned pd_gap(input dtg_cmd_t c, input dtg_burst_t b, input bit ap);
    // write to powerdown; fixed chop4 saves two cycles
    if (c == DTG_CMD_WR) return o_wl + ((b == DTG_CHOP_FIXED) ? 2 : 4) + WR_NCK + (ap ? 1 : 0);
    if (c == DTG_CMD_RD) return RL_NCK + 5;
    if (c == DTG_CMD_MRS) return TMOD_NCK;
    return 2;
  endfunction
  task automatic drive(input logic v, input dtg_cmd_t c, input dtg_burst_t b);
    @(negedge i_core_clk);
    o_cmd_valid = v;
    o_cmd = c;
    o_burst = b;
  endtask
  task automatic issue(input dtg_cmd_t c, input dtg_burst_t b);
    drive(1'b1, c, b);
    drive(1'b0, DTG_CMD_DES, b);
  endtask
  // refresh spacing: two idle edges before clock enable drops
  task automatic pd_enter();
    issue(DTG_CMD_REF, DTG_BL8);
    repeat (pd_gap(DTG_CMD_REF, DTG_BL8, 1'b0)) @(negedge i_core_clk);
    o_cke = 1'b0;
  endtask
  task automatic pd_exit();
    @(negedge i_core_clk);
    o_cke = 1'b1;
  endtask
endmodule // dtg_ctrl_model
`default_nettype wire

// ### test/tb_ddr4_command_timing_guard.sv
// Bench for the timing guard: write start, alert pulses, refusal, powerdown.
// Assumes the controller model drives commands; error pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr4_command_timing_guard;
  import dtg_pkg::*;
  logic i_core_clk, i_rst, par, crc, vld, cke, alert_n, exec, wrs, dll, pda;
  dtg_cmd_t cmd;
  dtg_burst_t bst;
  logic [LAT_W-1:0] wl;
  int n_mismatch, samples_checked, cyc, kf, kc, d, w, nl;
  dtg_ctrl_model ctrl_i (.i_core_clk(i_core_clk), .o_cmd_valid(vld), .o_cmd(cmd),
    .o_burst(bst), .o_wl(wl), .o_cke(cke));
  dtg_guard dtg_guard_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd_valid(vld),
    .i_cmd(cmd), .i_burst(bst), .i_wl(wl), .i_par_err_pin(par), .i_crc_err_pin(crc),
    .i_cke(cke), .o_alert_n(alert_n), .o_cmd_exec(exec), .o_wr_start(wrs),
    .o_cmd_needs_dll(dll), .o_pd_active(pda));
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi, input string m);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("BAD %0t %s got %0d", $time, m, got);
    end
  endtask
  task automatic wait_wr(output int k);
    k = 0;
    while (wrs !== 1'b1 && k < 40) begin
      @(negedge i_core_clk);
      k++;
    end
  endtask
  // Counts cycles to alert and its width; refusals counted alongside
  task automatic err_pulse(input bit p, output int dl, output int wd, output int lows);
    dl = 0;
    wd = 0;
    lows = 0;
    @(negedge i_core_clk);
    if (p) par = 1'b1;
    else crc = 1'b1;
    while (alert_n !== 1'b0 && dl < 30) begin
      @(negedge i_core_clk);
      dl++;
      if (exec !== 1'b1) lows++;
    end
    while (alert_n === 1'b0 && wd < 200) begin
      @(negedge i_core_clk);
      wd++;
      if (exec !== 1'b1) lows++;
    end
    par = 1'b0;
    crc = 1'b0;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {par, crc, n_mismatch, samples_checked, cyc} = '0;
    i_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_rst = 1'b0;
    chk_bit(alert_n, 1'b1, "alert after reset");
    ctrl_i.issue(DTG_CMD_WR, DTG_OTF);
    wait_wr(kf);
    ctrl_i.issue(DTG_CMD_WR, DTG_CHOP_FIXED);
    wait_wr(kc);
    chk_rng(kf, 9, 10, "write start burst8");
    chk_rng(kf - kc, 2, 2, "write start chop4 offset");
    $display("write start test done");
    ctrl_i.drive(1'b1, DTG_CMD_RD, DTG_BL8);
    #1 chk_bit(dll, 1'b1, "read needs dll");
    ctrl_i.drive(1'b1, DTG_CMD_ACT, DTG_BL8);
    #1 chk_bit(dll, 1'b0, "activate needs no dll");
    chk_bit(exec, 1'b1, "command accepted");
    ctrl_i.drive(1'b1, DTG_CMD_DES, DTG_BL8);
    $display("dll test done");
    err_pulse(1'b0, d, w, nl);
    chk_rng(d, 1, 6, "crc alert delay");
    chk_rng(w, 6, 10, "crc alert width");
    $display("crc alert test done");
    repeat (3) @(negedge i_core_clk);
    err_pulse(1'b1, d, w, nl);
    chk_rng(d, 1, PL_NCK + 6, "parity alert delay");
    chk_rng(w, 72, 144, "parity alert width");
    // The errant cycle itself is refused as well as the PL cycles after it
    chk_rng(nl, PL_NCK + 1, PL_NCK + 1, "refused window");
    ctrl_i.drive(1'b0, DTG_CMD_DES, DTG_BL8);
    $display("parity alert test done");
    ctrl_i.pd_enter();
    repeat (6) @(negedge i_core_clk);
    chk_bit(pda, 1'b1, "powerdown entered after refresh");
    ctrl_i.pd_exit();
    repeat (3) @(negedge i_core_clk);
    chk_bit(pda, 1'b0, "powerdown left");
    $display("powerdown test done");
    conclude();
  end
endmodule // tb_ddr4_command_timing_guard
`default_nettype wire
